// ===== hdl/scm_chan_stepper.sv
/*
 * Channel stepper of the secondary converter: walks the enabled balance
 * channels in ascending order, dwelling a fixed time on each.
 * Assumes the enable mask is held steady while a walk runs.
 */
`timescale 1ns/1ns
module scm_chan_stepper (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst_n,
   // Control.
   input wire logic start,
   input wire logic [15:0] chan_mask,
   // Status.
   output logic [3:0] chan,
   output logic busy,
   output logic chan_done,
   output logic done
);

   typedef struct packed {
      scm_pkg::scm_step_state_t state;
      logic [3:0] chan;
      logic [scm_pkg::CNT_W-1:0] cnt;
      logic busy;
      logic chan_done;
      logic done;
   } scm_step_st_t;

   scm_step_st_t st;
   scm_step_st_t next_st;
   logic [4:0] first_hit;
   logic [4:0] next_hit;

   // Lowest enabled channel at or above from; bit 4 flags a hit.
   function automatic logic [4:0] scm_find_from(input logic [15:0] mask,
                                                input logic [4:0] from);
      logic [4:0] r;
      r = 5'h00;
      for (int i = 15; i >= 0; i--) begin
         if (mask[i] && (5'(i) >= from)) begin
            r = {1'b1, 4'(i)};
         end
      end
      return r;
   endfunction

   assign first_hit = scm_find_from(chan_mask, 5'h00);
   assign next_hit = scm_find_from(chan_mask, {1'b0, st.chan} + 5'h01);

   always_comb begin
      next_st = st;
      next_st.chan_done = 1'b0;
      next_st.done = 1'b0;
      case (st.state)
         scm_pkg::SCM_STEP_IDLE: begin
            if (start) begin
               if (first_hit[4]) begin
                  next_st.state = scm_pkg::SCM_STEP_DWELL;
                  next_st.chan = first_hit[3:0];
                  next_st.cnt = '0;
                  next_st.busy = 1'b1;
               end else begin
                  next_st.done = 1'b1;
               end
            end
         end
         scm_pkg::SCM_STEP_DWELL: begin
            if (st.cnt ==
                scm_pkg::CNT_W'(scm_pkg::DWELL_CYCLES - 1)) begin
               next_st.chan_done = 1'b1;
               next_st.cnt = '0;
               if (next_hit[4]) begin
                  next_st.chan = next_hit[3:0];
               end else begin
                  next_st.state = scm_pkg::SCM_STEP_IDLE;
                  next_st.busy = 1'b0;
                  next_st.done = 1'b1;
               end
            end else begin
               next_st.cnt = st.cnt + 1'b1;
            end
         end
         default: begin
            next_st = '0;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign chan = st.chan;
   assign busy = st.busy;
   assign chan_done = st.chan_done;
   assign done = st.done;

   property p_dwell_length;
      @(posedge ref_clk) disable iff (!rst_n)
      (st.busy && st.cnt == '0 && !st.chan_done) |->
         (!next_st.chan_done)[*8];
   endproperty
   a_dwell_length: assert property (p_dwell_length)
      else $error("Channel dwell ended too early.");

   property p_ascending;
      @(posedge ref_clk) disable iff (!rst_n)
      (st.chan_done && st.busy) |-> (st.chan > $past(st.chan));
   endproperty
   a_ascending: assert property (p_ascending)
      else $error("Channel walk did not ascend.");

endmodule // scm_chan_stepper

// ===== hdl/scm_sync_meas_ctrl.sv
/*
 * Control of the secondary measurement chain: APB registers, paired and
 * fast balance-voltage cycles, balancing pause and open-load selection.
 * Assumes a single 20 MHz clock, an APB master and a balancing block
 * that reports whether balancing is already paused.
 */
//
// Contract
// - Pause request delays capture until auto-pause elapses; with bal_paused already set, capture starts at once.
// - Pause bit ignored without a cycle start.
// - Selector 0..17 enables that channel's open-load.
// - Selector 18..29 enables no open-load detection.
// - Selector 30 follows the measured channel.
// - Selector 1Fh, the reset value, disables open-load.
// - Fast start bit launches cycle, reads zero.
// - Each channel dwells 28 sample periods.
// - Paired start bit starts cycle, reads zero.
// - Paired cycle stores terminal and balance pairs.
// - Paired start ignored if none enabled or busy.
// - Bits 9:2 of control always read zero.
// - Enable bit n includes channel n.
`timescale 1ns/1ns
module scm_sync_meas_ctrl (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst_n,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Balancing.
   input wire logic bal_paused,
   output logic bal_pause,
   // Secondary converter.
   output logic [3:0] conv_channel,
   output logic conv_active,
   output logic conv_pair_mode,
   output logic pair_store,
   output logic fast_store,
   output logic cycle_done,
   // Open-load detection and channel enables.
   output logic [17:0] ol_enable,
   output logic [15:0] vb_enable
);

   typedef struct packed {
      scm_pkg::scm_state_t state;
      logic sync_mode;
      logic [scm_pkg::CNT_W-1:0] pause_cnt;
      logic [4:0] ol_sel;
      logic [15:0] vb_en;
      logic bal_pause;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic pair_store;
      logic fast_store;
      logic cycle_done;
      logic [17:0] ol_en;
      logic step_start;
   } scm_top_st_t;

   localparam scm_top_st_t ST_RESET = '{
      state: scm_pkg::SCM_IDLE,
      ol_sel: scm_pkg::OLSEL_RESET,
      vb_en: scm_pkg::VBEN_RESET,
      default: '0
   };

   // Helper bound for the pause-wait check below.
   localparam int AP_BOUND = 201;

   scm_top_st_t st;
   scm_top_st_t next_st;
   logic [3:0] step_chan;
   logic step_busy;
   logic step_chan_done;
   logic step_done;
   logic setup;
   logic access;
   logic hit_ctrl;
   logic hit_vben;
   logic wr_ctrl;
   logic sync_req;
   logic fast_req;
   logic accept;

   function automatic logic [17:0] scm_ol_onehot(input logic [4:0] n);
      return 18'h00001 << n;
   endfunction

   scm_chan_stepper u_stepper (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .start(st.step_start),
      .chan_mask(st.vb_en),
      .chan(step_chan),
      .busy(step_busy),
      .chan_done(step_chan_done),
      .done(step_done)
   );

   assign setup = psel && !penable;
   assign access = psel && penable && st.pready;
   assign hit_ctrl = (paddr == scm_pkg::CTRL_ADDR);
   assign hit_vben = (paddr == scm_pkg::VBEN_ADDR);
   assign wr_ctrl = access && pwrite && hit_ctrl;
   assign sync_req = wr_ctrl && pwdata[scm_pkg::SYNC_BIT];
   assign fast_req = wr_ctrl && pwdata[scm_pkg::FAST_BIT];
   // Enables are checked before a start; a cycle over no channel is refused.
   assign accept = (st.state == scm_pkg::SCM_IDLE) && !step_busy &&
                   (sync_req || fast_req) && (|st.vb_en);

   always_comb begin
      next_st = st;
      next_st.pair_store = 1'b0;
      next_st.fast_store = 1'b0;
      next_st.cycle_done = 1'b0;
      next_st.step_start = 1'b0;

      // Read data is prepared in the setup phase, so the access phase completes with no wait state.
      next_st.pready = setup;
      next_st.pslverr = setup && !(hit_ctrl || hit_vben);
      if (setup) begin
         if (hit_ctrl) begin
            next_st.prdata = {16'h0000, 1'b0, st.ol_sel, 10'h000};
         end else if (hit_vben) begin
            next_st.prdata = {16'h0000, st.vb_en};
         end else begin
            next_st.prdata = 32'h00000000;
         end
      end

      if (wr_ctrl) begin
         next_st.ol_sel = pwdata[scm_pkg::OLSEL_MSB:scm_pkg::OLSEL_LSB];
      end
      if (access && pwrite && hit_vben) begin
         next_st.vb_en = pwdata[15:0];
      end

      case (st.state)
         scm_pkg::SCM_IDLE: begin
            if (accept) begin
               // Paired request wins when both start bits are written.
               next_st.sync_mode = sync_req;
               if (pwdata[scm_pkg::PAUSE_BIT] && !bal_paused) begin
                  next_st.bal_pause = 1'b1;
                  next_st.state = scm_pkg::SCM_PAUSE_WAIT;
                  next_st.pause_cnt =
                     scm_pkg::CNT_W'(scm_pkg::AUTO_PAUSE_CYCLES - 1);
               end else begin
                  next_st.bal_pause = pwdata[scm_pkg::PAUSE_BIT];
                  next_st.state = scm_pkg::SCM_RUN;
                  next_st.step_start = 1'b1;
               end
            end
         end
         scm_pkg::SCM_PAUSE_WAIT: begin
            if (st.pause_cnt == '0) begin
               next_st.state = scm_pkg::SCM_RUN;
               next_st.step_start = 1'b1;
            end else begin
               next_st.pause_cnt = st.pause_cnt - 1'b1;
            end
         end
         scm_pkg::SCM_RUN: begin
            next_st.pair_store = step_chan_done && st.sync_mode;
            next_st.fast_store = step_chan_done && !st.sync_mode;
            if (step_done) begin
               next_st.state = scm_pkg::SCM_IDLE;
               next_st.bal_pause = 1'b0;
               next_st.cycle_done = 1'b1;
            end
         end
         default: begin
            next_st.state = scm_pkg::SCM_IDLE;
         end
      endcase

      if (st.ol_sel <= scm_pkg::OLSEL_LAST_CHAN) begin
         next_st.ol_en = scm_ol_onehot(st.ol_sel);
      end else if (st.ol_sel == scm_pkg::OLSEL_FOLLOW && step_busy) begin
         next_st.ol_en = scm_ol_onehot({1'b0, step_chan});
      end else begin
         next_st.ol_en = 18'h00000;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= ST_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign prdata = st.prdata;
   assign pready = st.pready;
   assign pslverr = st.pslverr;
   assign bal_pause = st.bal_pause;
   assign conv_channel = step_chan;
   assign conv_active = step_busy;
   assign conv_pair_mode = st.sync_mode;
   assign pair_store = st.pair_store;
   assign fast_store = st.fast_store;
   assign cycle_done = st.cycle_done;
   assign ol_enable = st.ol_en;
   assign vb_enable = st.vb_en;

   property p_pause_holds;
      @(posedge ref_clk) disable iff (!rst_n)
      (st.state == scm_pkg::SCM_PAUSE_WAIT) |-> (!step_busy && st.bal_pause);
   endproperty
   a_pause_holds: assert property (p_pause_holds)
      else $error("Capture started during the auto-pause wait.");

   property p_pause_bounded;
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(st.state == scm_pkg::SCM_PAUSE_WAIT) |->
         ##[1:AP_BOUND] (st.state == scm_pkg::SCM_RUN);
   endproperty
   a_pause_bounded: assert property (p_pause_bounded)
      else $error("Auto-pause wait did not end in time.");

   property p_pause_ignored;
      @(posedge ref_clk) disable iff (!rst_n)
      (wr_ctrl && pwdata[scm_pkg::PAUSE_BIT] && !accept &&
       st.state == scm_pkg::SCM_IDLE) |=> !st.bal_pause;
   endproperty
   a_pause_ignored: assert property (p_pause_ignored)
      else $error("Pause bit acted without a cycle start.");

   property p_ol_fixed;
      @(posedge ref_clk) disable iff (!rst_n)
      (st.ol_sel <= 5'h11 && $stable(st.ol_sel)) |->
         (st.ol_en == (18'h00001 << st.ol_sel));
   endproperty
   a_ol_fixed: assert property (p_ol_fixed)
      else $error("Open-load enable does not match the selected channel.");

   property p_ol_none;
      @(posedge ref_clk) disable iff (!rst_n)
      ((st.ol_sel >= 5'h12 && st.ol_sel != 5'h1e) && $stable(st.ol_sel))
         |-> (st.ol_en == 18'h00000);
   endproperty
   a_ol_none: assert property (p_ol_none)
      else $error("Open-load enabled for a reserved or disabled selector.");

   property p_ol_follow;
      @(posedge ref_clk) disable iff (!rst_n)
      (st.ol_sel == 5'h1e && $stable(st.ol_sel) && $past(step_busy) &&
       $stable(step_chan)) |-> (st.ol_en == (18'h00001 << step_chan));
   endproperty
   a_ol_follow: assert property (p_ol_follow)
      else $error("Open-load does not follow the measured channel.");

   property p_ctrl_reads_zero;
      @(posedge ref_clk) disable iff (!rst_n)
      (st.pready && hit_ctrl && !pwrite) |->
         (st.prdata[9:0] == 10'h000 && st.prdata[15] == 1'b0);
   endproperty
   a_ctrl_reads_zero: assert property (p_ctrl_reads_zero)
      else $error("Start or reserved bits read back non-zero.");

   property p_start_taken;
      @(posedge ref_clk) disable iff (!rst_n)
      (wr_ctrl && pwdata[scm_pkg::FAST_BIT] && !pwdata[scm_pkg::SYNC_BIT] &&
       st.state == scm_pkg::SCM_IDLE && !step_busy && (|st.vb_en)) |=>
         (st.state != scm_pkg::SCM_IDLE && !st.sync_mode);
   endproperty
   a_start_taken: assert property (p_start_taken)
      else $error("Fast cycle start was not taken.");

   property p_start_refused;
      @(posedge ref_clk) disable iff (!rst_n)
      (sync_req && (st.vb_en == 16'h0000 || st.state != scm_pkg::SCM_IDLE))
         |=> $stable(st.sync_mode);
   endproperty
   a_start_refused: assert property (p_start_refused)
      else $error("Paired cycle start was not refused.");

   property p_pair_only_sync;
      @(posedge ref_clk) disable iff (!rst_n)
      st.pair_store |->
         (st.sync_mode && !st.fast_store && $past(step_chan_done));
   endproperty
   a_pair_only_sync: assert property (p_pair_only_sync)
      else $error("Pair stored outside a paired cycle.");

   property p_enabled_only;
      @(posedge ref_clk) disable iff (!rst_n)
      step_busy |-> st.vb_en[step_chan];
   endproperty
   a_enabled_only: assert property (p_enabled_only)
      else $error("A disabled channel is being measured.");

endmodule // scm_sync_meas_ctrl

// ===== shared/scm_pkg.sv
/*
 * Shared constants and types of the secondary measurement chain control:
 * register indices and byte addresses, field positions, reset values,
 * timing counts and state encodings.
 * Assumes a 20 MHz device clock and a 32-bit APB register bus.
 */
package scm_pkg;

   // APB geometry. Printed offsets are word indices; bytes are four apart.
   localparam int ADDR_W = 16;
   localparam int CTRL_IDX = 'h1c03;
   localparam int VBEN_IDX = 'h1c08;
   localparam logic [15:0] CTRL_ADDR = 16'(CTRL_IDX * 4);
   localparam logic [15:0] VBEN_ADDR = 16'(VBEN_IDX * 4);

   // Synchronous control register fields.
   localparam int SYNC_BIT = 0;
   localparam int FAST_BIT = 1;
   localparam int OLSEL_LSB = 10;
   localparam int OLSEL_MSB = 14;
   localparam int PAUSE_BIT = 15;
   localparam logic [4:0] OLSEL_RESET = 5'h1f;
   localparam logic [4:0] OLSEL_LAST_CHAN = 5'h11;
   localparam logic [4:0] OLSEL_FOLLOW = 5'h1e;
   localparam logic [15:0] VBEN_RESET = 16'h0000;

   // Channel counts.
   localparam int NUM_VB = 16;
   localparam int NUM_OL = 18;

   // Timing. The sample period and auto-pause time are plain defaults.
   localparam int CLK_PERIOD_NS = 50;
   localparam int SAMPLE_PERIOD_NS = 1000;
   localparam int SAMPLE_CYCLES =
      (SAMPLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DWELL_MULT = 28;
   localparam int DWELL_CYCLES = DWELL_MULT * SAMPLE_CYCLES;
   localparam int AUTO_PAUSE_NS = 10000;
   localparam int AUTO_PAUSE_CYCLES =
      (AUTO_PAUSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 12;

   typedef enum logic [1:0] {
      SCM_IDLE = 2'b00,
      SCM_PAUSE_WAIT = 2'b01,
      SCM_RUN = 2'b10
   } scm_state_t;

   typedef enum logic {
      SCM_STEP_IDLE = 1'b0,
      SCM_STEP_DWELL = 1'b1
   } scm_step_state_t;

endpackage

// ===== sim/scm_tb.sv
/*
 * Self-checking bench of the secondary measurement chain control: APB
 * register access, open-load selection, paired and fast cycles, pause.
 * Assumes the design answers APB with no wait state, as noted.
 */
`timescale 1ns/1ns
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
   err_total++; $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
   end end
module testbench;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic bal_paused = 1'b0;
   logic bal_pause;
   logic [3:0] conv_channel;
   logic conv_active;
   logic conv_pair_mode;
   logic pair_store;
   logic fast_store;
   logic cycle_done;
   logic [17:0] ol_enable;
   logic [15:0] vb_enable;
   int err_total = 0;
   int samples_checked = 0;
   int act_cyc, pm_cyc, ol_bad, pair_cnt, fast_cnt, done_cnt, lat;
   logic [3:0] chq[$];
   logic prev_act = 1'b0;
   logic [3:0] prev_ch = 4'h0;
   logic [31:0] rd;
   logic er;
   logic pw;
   logic [4:0] sels[5] = '{5'h05, 5'h11, 5'h12, 5'h1d, 5'h1f};
   logic [17:0] ols[5] = '{18'h00020, 18'h20000, 18'h0, 18'h0, 18'h0};

   scm_sync_meas_ctrl u_scm_sync_meas_ctrl (
      .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .bal_paused(bal_paused),
      .bal_pause(bal_pause), .conv_channel(conv_channel),
      .conv_active(conv_active), .conv_pair_mode(conv_pair_mode),
      .pair_store(pair_store), .fast_store(fast_store),
      .cycle_done(cycle_done), .ol_enable(ol_enable),
      .vb_enable(vb_enable)
   );

   always #25 ref_clk = ~ref_clk;

   // Records each channel as the walk enters it and counts the pulses.
   always @(posedge ref_clk) begin
      if (conv_active) begin
         act_cyc++;
         if (conv_pair_mode) pm_cyc++;
         if (!prev_act || conv_channel !== prev_ch)
            chq.push_back(conv_channel);
         else if (ol_enable !== (18'h1 << conv_channel)) ol_bad++;
      end
      if (pair_store) pair_cnt++;
      if (fast_store) fast_cnt++;
      if (cycle_done) done_cnt++;
      prev_act = conv_active;
      prev_ch = conv_channel;
   end

   task automatic apb(input logic w, input logic [15:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) err_total++;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Starts a cycle, optionally pokes a second start mid-walk, waits done.
   task automatic run(input logic [31:0] w, input logic poke);
      int n;
      act_cyc = 0;
      pm_cyc = 0;
      ol_bad = 0;
      pair_cnt = 0;
      fast_cnt = 0;
      done_cnt = 0;
      pw = 1'b0;
      chq.delete();
      apb(1'b1, scm_pkg::CTRL_ADDR, w, rd, er);
      lat = 0;
      do begin
         @(posedge ref_clk);
         lat++;
         pw |= bal_pause;
      end while (conv_active !== 1'b1 && lat < 400);
      // The poke keeps the selector at 30 so the open-load check holds.
      if (poke) apb(1'b1, scm_pkg::CTRL_ADDR, 32'h0000_7803, rd, er);
      n = 0;
      while (lat < 400 && done_cnt == 0 && n < 5000) begin
         @(posedge ref_clk);
         n++;
      end
      // A walk that started and never finished counts as a mismatch.
      if (lat < 400 && done_cnt == 0) err_total++;
      repeat (8) @(posedge ref_clk);
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge ref_clk);
      err_total++;
      stop_test();
   end

   initial begin
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      apb(1'b0, scm_pkg::CTRL_ADDR, 32'h0, rd, er);
      `CHK(rd, 32'h0000_7c00)
      `CHK(ol_enable, 18'h0)
      apb(1'b0, scm_pkg::VBEN_ADDR, 32'h0, rd, er);
      `CHK(rd, 32'h0)
      apb(1'b0, 16'h0000, 32'h0, rd, er);
      `CHK({er, rd}, 33'h1_0000_0000)
      $display("test reset done");

      // Reserved bits and the pause bit never read back; the start bits are not written here.
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, scm_pkg::CTRL_ADDR,
             32'h83ff & ~32'h3 | ({27'h0, sels[i]} << 10), rd, er);
         repeat (2) @(posedge ref_clk);
         `CHK(ol_enable, ols[i])
         `CHK(bal_pause, 1'b0)
         apb(1'b0, scm_pkg::CTRL_ADDR, 32'h0, rd, er);
         `CHK(rd, {22'h0, sels[i]} << 10)
      end
      $display("test selector done");

      // With no channel enabled, neither start kind may run.
      run(32'h0000_0001, 1'b0);
      `CHK(act_cyc, 0)
      run(32'h0000_0002, 1'b0);
      `CHK(act_cyc, 0)
      $display("test refused done");

      // Enables are only written between cycles, never during a walk.
      apb(1'b1, scm_pkg::VBEN_ADDR, 32'h0000_8002, rd, er);
      apb(1'b0, scm_pkg::VBEN_ADDR, 32'h0, rd, er);
      `CHK(rd, 32'h0000_8002)
      `CHK(vb_enable, 16'h8002)
      run(32'h0000_7801, 1'b1);
      `CHK(lat <= 3, 1'b1)
      `CHK(chq.size(), 2)
      `CHK(chq[0], 4'h1)
      `CHK(chq[1], 4'hf)
      `CHK(act_cyc, 2 * scm_pkg::DWELL_CYCLES)
      `CHK(pm_cyc, act_cyc)
      `CHK(pair_cnt, 2)
      `CHK(fast_cnt, 0)
      `CHK(ol_bad, 0)
      `CHK(done_cnt, 1)
      `CHK(conv_active, 1'b0)
      $display("test paired done");

      apb(1'b1, scm_pkg::VBEN_ADDR, 32'h0000_0001, rd, er);
      run(32'h0000_fc02, 1'b0);
      `CHK(lat >= scm_pkg::AUTO_PAUSE_CYCLES, 1'b1)
      `CHK(pw, 1'b1)
      `CHK(bal_pause, 1'b0)
      `CHK(fast_cnt, 1)
      `CHK(pair_cnt, 0)
      `CHK(pm_cyc, 0)
      `CHK(chq[0], 4'h0)
      `CHK(act_cyc, scm_pkg::DWELL_CYCLES)
      $display("test fast pause done");

      // Balancing already paused: capture starts without the wait.
      // Both start bits together must give a paired cycle.
      bal_paused <= 1'b1;
      run(32'h0000_f803, 1'b0);
      `CHK(lat <= 3, 1'b1)
      `CHK(pw, 1'b1)
      `CHK(pair_cnt, 1)
      `CHK(fast_cnt, 0)
      $display("test paused done");
      stop_test();
   end
endmodule // testbench
